/* File: src/core_pkg.sv */
/*
 Constants, types and the register map of the execution core.
 Assumes a byte-addressed Wishbone master and byte offsets below.
*/
package core_pkg;
   // Wishbone register byte offsets
   localparam logic [7:0] ADR_STATUS = 8'h00;
   localparam logic [7:0] ADR_CTRL   = 8'h04;
   localparam logic [7:0] ADR_PC     = 8'h08;
   localparam logic [7:0] ADR_SP     = 8'h0C;
   localparam logic [7:0] ADR_IEN    = 8'h10;
   localparam logic [7:0] ADR_PROG   = 8'h14;
   localparam logic [7:0] ADR_BOOT   = 8'h18;
   localparam logic [7:0] ADR_REGWIN = 8'h80;
   // Control bits
   localparam int CTRL_RUN     = 0;
   localparam int CTRL_VEC2    = 1;
   localparam int CTRL_BOOTSEC = 2;
   // Status flag positions
   localparam int SR_I = 7;
   localparam int SR_T = 6;
   localparam int SR_H = 5;
   localparam int SR_S = 4;
   localparam int SR_V = 3;
   localparam int SR_N = 2;
   localparam int SR_Z = 1;
   localparam int SR_C = 0;
   // Reset values
   localparam logic [7:0]  STATUS_FLAG_REGISTER_RST = 8'h00;
   localparam logic [7:0]  CTRL_RST = 8'h00;
   localparam logic [15:0] BOOT_RST = 16'h0000;
   localparam logic [15:0] PC_RST   = 16'h0000;
   // Data space map
   localparam logic [15:0] DS_IO_BASE = 16'h0020;
   localparam logic [15:0] DS_SPL     = 16'h005D;
   localparam logic [15:0] DS_SPH     = 16'h005E;
   localparam logic [15:0] DS_STATUS_FLAG_REGISTER    = 16'h005F;
   localparam logic [4:0]  PTR_X      = 5'h1A;
   localparam logic [4:0]  PTR_Z      = 5'h1E;
   localparam logic [15:0] RET_STEP   = 16'h0002;
   // Opcode field [15:12]
   localparam logic [3:0] OP_MISC   = 4'h0;
   localparam logic [3:0] OP_SINGLE = 4'h1;
   localparam logic [3:0] OP_BITCP  = 4'h2;
   localparam logic [3:0] OP_BRANCH = 4'h3;
   localparam logic [3:0] OP_LONG   = 4'h4;
   localparam logic [3:0] OP_IO     = 4'h5;
   localparam logic [3:0] OP_IND    = 4'h6;
   // Misc sub-codes [11:8]
   localparam logic [3:0] MS_OPEN  = 4'h1;
   localparam logic [3:0] MS_CLOSE = 4'h2;
   localparam logic [3:0] MS_RET   = 4'h3;
   localparam logic [3:0] MS_RETURN_FROM_IRQ  = 4'h4;
   localparam logic [3:0] MS_SPM   = 4'h5;
   localparam logic [3:0] MS_LPM   = 4'h6;
   // Two-word kinds [11:10]
   localparam logic [1:0] LW_JMP  = 2'h0;
   localparam logic [1:0] LW_CALL = 2'h1;
   localparam logic [1:0] LW_LDS  = 2'h2;
   localparam logic [1:0] LW_STS  = 2'h3;

   typedef enum logic [3:0] {
      A_ADD = 4'h0, A_ADC = 4'h1, A_SUB = 4'h2, A_SBC = 4'h3,
      A_AND = 4'h4, A_OR  = 4'h5, A_EOR = 4'h6, A_MOV = 4'h7,
      A_INC = 4'h8, A_DEC = 4'h9, A_COM = 4'hA, A_NEG = 4'hB,
      A_LSR = 4'hC, A_ROR = 4'hD, A_ASR = 4'hE, A_SWAP = 4'hF
   } alu_op_e;

   typedef enum logic [1:0] {ST_HALT = 2'b01, ST_RUN = 2'b10} core_state_e;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_s;

   typedef struct packed {
      logic [7:0] sr;
      logic [7:0] res;
   } alu_out_s;
endpackage : core_pkg

/* File: src/exec_core.sv */
/*
 Eight-bit execution core: prefetch, register file, ALU, status flags,
 stack, vectored interrupts, program store, Wishbone register slave.
 Assumes level interrupt requests from another clock domain.
*/
`timescale 1ns/100ps
// Functional notes
// - Next word is prefetched while the current one executes.
// - 32 byte registers; two operands read, result written, one clock.
// - Four register pairs are data pointers, r1:r0 by wrap; one also reads program memory.
// - ALU does reg-reg, reg-immediate and single-register ops in one clock.
// - Decoder takes one-word and two-word instructions.
// - Call and interrupt push the return address onto the data-memory stack.
// - One vector per source; lowest vector wins.
// - Vector entries are one or two words by variant.
// - 64 I/O addresses, also data addresses 0x20 to 0x5F.
// - Extended I/O 0x60 to 0xFF only by data load and store.
// - Flags updated after each ALU operation except move and swap.
// - Flags neither saved nor restored around interrupts.
// - Bit 7 clear blocks every interrupt.
// - Gate cleared on entry, set on interrupt return, set and cleared by opcodes.
// - Bit 6 is a bit copy store for the two bit copy opcodes.
// - Bit 5 is the low nibble carry.
// - Bit 4 equals negative XOR overflow.
// - Bit 3 is two's complement overflow.
// - Program store runs only from the boot section when one exists.
// - Bits 2, 1, 0 are negative, zero and carry.
// - Return address push lowers the stack top by two.
module exec_core #(
   parameter int          PMEM_DEPTH = 256,
   parameter logic [15:0] DS_SIZE    = 16'h0200,
   parameter int          NIRQ       = 8
) (
   input  wire logic             CLK,
   input  wire logic             RST_B,
   input  wire core_pkg::wb_req_s WB_REQ,
   output core_pkg::wb_rsp_s     WB_RSP,
   input  wire logic [NIRQ-1:0]  IRQ,
   output logic      [NIRQ-1:0]  IRQ_ACK
);
   localparam int          PAW  = $clog2(PMEM_DEPTH);
   localparam int          DMN  = int'(DS_SIZE) - 32;
   localparam int          DAW  = $clog2(DMN);
   localparam logic [15:0] SP_RST = DS_SIZE - 16'h0001;

   core_pkg::core_state_e state_r;
   core_pkg::wb_rsp_s     rsp_r;
   core_pkg::alu_op_e     alu_op;
   core_pkg::alu_out_s    aluo;
   logic [7:0]      rf [32];
   logic [7:0]      dmem [DMN];
   logic [15:0]     pmem [PMEM_DEPTH];
   logic [15:0]     pc_r, ir_r, ir_pc_r, sp_r, boot_r;
   logic            ir_vld_r;
   logic [7:0]      status_flag_register_r, ctrl_r;
   logic [NIRQ-1:0] ien_r, irq_s1_r, irq_s2_r, irq_ack_r;
   logic [15:0]     pc_nxt, ir_nxt, ir_pc_nxt, sp_nxt, ma_addr, p_wd, opw, zp;
   logic            ir_vld_nxt, rf_we, p_we, ma_en, ma_wr, dm_we, push, pm_we, alu_is;
   logic [7:0]      status_flag_register_nxt, rf_wd, ma_wd, dm_wd, alu_a, alu_b;
   logic [4:0]      rf_wa, p_wa, ma_rd, alu_d;
   logic [15:0]     push_pc, pm_wd;
   logic [NIRQ-1:0] ack_nxt, pend;
   logic [2:0]      irq_idx;
   logic            run, halted, acc, bus_wr, take_irq;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [DAW-1:0] didx(input logic [15:0] a);
      logic [15:0] o;
      o = a - core_pkg::DS_IO_BASE;
      return o[DAW-1:0];
   endfunction : didx

   function automatic logic [7:0] ds_read(input logic [15:0] a);
      ds_read = 8'h00;
      if (a < core_pkg::DS_IO_BASE) ds_read = rf[a[4:0]];
      else if (a == core_pkg::DS_STATUS_FLAG_REGISTER) ds_read = status_flag_register_r;
      else if (a == core_pkg::DS_SPL) ds_read = sp_r[7:0];
      else if (a == core_pkg::DS_SPH) ds_read = sp_r[15:8];
      else if (a < DS_SIZE) ds_read = dmem[didx(a)];
   endfunction : ds_read

   function automatic core_pkg::alu_out_s alu_f(input core_pkg::alu_op_e op,
                                                input logic [7:0] a,
                                                input logic [7:0] b,
                                                input logic [7:0] sr);
      logic [8:0] s;
      logic [4:0] hs;
      logic [7:0] x, y;
      logic       cin, c, h, v;
      core_pkg::alu_out_s o;
      cin = sr[core_pkg::SR_C] & (op == core_pkg::A_ADC || op == core_pkg::A_SBC);
      x = (op == core_pkg::A_NEG) ? 8'h00 : a;
      y = (op == core_pkg::A_NEG) ? a : b;
      s = 9'h000;
      hs = 5'h00;
      c = sr[core_pkg::SR_C];
      h = sr[core_pkg::SR_H];
      v = 1'b0;
      case (op)
         core_pkg::A_ADD, core_pkg::A_ADC: begin
            s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            c = s[8];
            h = hs[4];
            v = (a[7] == b[7]) && (s[7] != a[7]);
         end
         core_pkg::A_SUB, core_pkg::A_SBC, core_pkg::A_NEG: begin
            s = {1'b0, x} - {1'b0, y} - {8'h00, cin};
            hs = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
            c = s[8];
            h = hs[4];
            v = (x[7] != y[7]) && (s[7] != x[7]);
         end
         core_pkg::A_AND: s = {1'b0, a & b};
         core_pkg::A_OR:  s = {1'b0, a | b};
         core_pkg::A_EOR: s = {1'b0, a ^ b};
         core_pkg::A_INC: begin
            s = {1'b0, a + 8'h01};
            v = (a == 8'h7F);
         end
         core_pkg::A_DEC: begin
            s = {1'b0, a - 8'h01};
            v = (a == 8'h80);
         end
         core_pkg::A_COM: begin
            s = {1'b0, ~a};
            c = 1'b1;
         end
         core_pkg::A_LSR, core_pkg::A_ROR, core_pkg::A_ASR: begin
            s[7] = (op == core_pkg::A_ROR) ? sr[core_pkg::SR_C] :
                   (op == core_pkg::A_ASR) ? a[7] : 1'b0;
            s[6:0] = a[7:1];
            c = a[0];
            v = s[7] ^ a[0];
         end
         default: s = {1'b0, b};
      endcase
      o.res = s[7:0];
      o.sr = sr;
      // Moves only copy data, so they leave the flags alone
      if (op != core_pkg::A_MOV && op != core_pkg::A_SWAP) begin
         o.sr[core_pkg::SR_C] = c;
         o.sr[core_pkg::SR_Z] = (s[7:0] == 8'h00);
         o.sr[core_pkg::SR_N] = s[7];
         o.sr[core_pkg::SR_V] = v;
         o.sr[core_pkg::SR_S] = s[7] ^ v;
         o.sr[core_pkg::SR_H] = h;
      end
      if (op == core_pkg::A_SWAP) o.res = {a[3:0], a[7:4]};
      return o;
   endfunction : alu_f

   ////////////////////////////////////////////////////////////////////////////
   assign run    = (state_r == core_pkg::ST_RUN);
   assign halted = (state_r == core_pkg::ST_HALT);
   assign acc    = WB_REQ.cyc & WB_REQ.stb;
   // Write commits at the edge the master sees ack
   assign bus_wr = acc & WB_REQ.we & rsp_r.ack;
   assign pend   = irq_s2_r & ien_r;
   assign take_irq = run & ir_vld_r & status_flag_register_r[core_pkg::SR_I] & (|pend);
   assign opw    = pmem[pc_r[PAW-1:0]];
   assign zp     = {rf[core_pkg::PTR_Z + 5'h01], rf[core_pkg::PTR_Z]};
   assign alu_is = ir_r[15] | (ir_r[15:12] == core_pkg::OP_SINGLE);
   assign aluo   = alu_f(alu_op, alu_a, alu_b, status_flag_register_r);

   always_comb begin
      irq_idx = 3'h0;
      for (int i = NIRQ - 1; i >= 0; i--) begin
         if (pend[i]) irq_idx = 3'(i);
      end
   end

   always_comb begin
      alu_op = core_pkg::A_MOV;
      alu_d = ir_r[9:5];
      alu_a = rf[ir_r[9:5]];
      alu_b = rf[ir_r[4:0]];
      if (ir_r[15:14] == 2'b11) begin
         alu_op = core_pkg::alu_op_e'({1'b0, ir_r[13:11]});
      end else if (ir_r[15:14] == 2'b10) begin
         alu_d = {1'b1, ir_r[11:8]};
         alu_a = rf[{1'b1, ir_r[11:8]}];
         alu_b = ir_r[7:0];
         case (ir_r[13:12])
            2'b01:   alu_op = core_pkg::A_ADD;
            2'b10:   alu_op = core_pkg::A_SUB;
            2'b11:   alu_op = core_pkg::A_AND;
            default: alu_op = core_pkg::A_MOV;
         endcase
      end else if (ir_r[15:12] == core_pkg::OP_SINGLE) begin
         alu_op = core_pkg::alu_op_e'({1'b1, ir_r[10:8]});
         alu_d = ir_r[4:0];
         alu_a = rf[ir_r[4:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      pc_nxt = pc_r + 16'h0001;
      ir_nxt = opw;
      ir_vld_nxt = 1'b1;
      ir_pc_nxt = pc_r;
      status_flag_register_nxt = status_flag_register_r;
      sp_nxt = sp_r;
      rf_we = 1'b0;
      rf_wa = alu_d;
      rf_wd = aluo.res;
      p_we = 1'b0;
      p_wa = core_pkg::PTR_X + {2'b00, ir_r[11:10], 1'b0};
      p_wd = {rf[p_wa + 5'h01], rf[p_wa]} + 16'h0001;
      ma_en = 1'b0;
      ma_wr = 1'b0;
      ma_addr = 16'h0000;
      ma_wd = rf[ir_r[4:0]];
      ma_rd = ir_r[4:0];
      dm_we = 1'b0;
      dm_wd = ma_wd;
      push = 1'b0;
      push_pc = pc_r;
      pm_we = 1'b0;
      pm_wd = {rf[1], rf[0]};
      ack_nxt = '0;
      if (!run) begin
         pc_nxt = pc_r;
         ir_nxt = ir_r;
         ir_vld_nxt = ir_vld_r;
         ir_pc_nxt = ir_pc_r;
      end else if (take_irq) begin
         push = 1'b1;
         push_pc = ir_pc_r;
         sp_nxt = sp_r - core_pkg::RET_STEP;
         status_flag_register_nxt[core_pkg::SR_I] = 1'b0;
         // Four bits, so the top source does not wrap onto the reset vector
         pc_nxt = {12'h000, {1'b0, irq_idx} + 4'h1} << ctrl_r[core_pkg::CTRL_VEC2];
         ir_vld_nxt = 1'b0;
         ack_nxt[irq_idx] = 1'b1;
      end else if (ir_vld_r && alu_is) begin
         rf_we = 1'b1;
         status_flag_register_nxt = aluo.sr;
      end else if (ir_vld_r) begin
         case (ir_r[15:12])
            core_pkg::OP_MISC: begin
               case (ir_r[11:8])
                  core_pkg::MS_OPEN:  status_flag_register_nxt[core_pkg::SR_I] = 1'b1;
                  core_pkg::MS_CLOSE: status_flag_register_nxt[core_pkg::SR_I] = 1'b0;
                  core_pkg::MS_RET, core_pkg::MS_RETURN_FROM_IRQ: begin
                     pc_nxt = {dmem[didx(sp_r + 16'h0001)],
                               dmem[didx(sp_r + core_pkg::RET_STEP)]};
                     sp_nxt = sp_r + core_pkg::RET_STEP;
                     ir_vld_nxt = 1'b0;
                     // Flags other than the gate are left as the handler set them
                     if (ir_r[11:8] == core_pkg::MS_RETURN_FROM_IRQ) status_flag_register_nxt[core_pkg::SR_I] = 1'b1;
                  end
                  core_pkg::MS_SPM: begin
                     pm_we = !ctrl_r[core_pkg::CTRL_BOOTSEC] || (ir_pc_r >= boot_r);
                  end
                  core_pkg::MS_LPM: begin
                     rf_we = 1'b1;
                     rf_wa = 5'h00;
                     rf_wd = zp[0] ? pmem[zp[PAW:1]][15:8] : pmem[zp[PAW:1]][7:0];
                  end
                  default: ;
               endcase
            end
            core_pkg::OP_BITCP: begin
               if (ir_r[11]) begin
                  rf_we = 1'b1;
                  rf_wa = ir_r[4:0];
                  rf_wd = rf[ir_r[4:0]];
                  rf_wd[ir_r[10:8]] = status_flag_register_r[core_pkg::SR_T];
               end else begin
                  status_flag_register_nxt[core_pkg::SR_T] = rf[ir_r[4:0]][ir_r[10:8]];
               end
            end
            core_pkg::OP_BRANCH: begin
               if (status_flag_register_r[ir_r[10:8]] == ir_r[11]) begin
                  pc_nxt = ir_pc_r + 16'h0001 + {{8{ir_r[7]}}, ir_r[7:0]};
                  ir_vld_nxt = 1'b0;
               end
            end
            core_pkg::OP_LONG: begin
               // Operand word is the one being prefetched
               pc_nxt = pc_r + 16'h0002;
               ir_nxt = pmem[PAW'(pc_r + 16'h0001)];
               ir_pc_nxt = pc_r + 16'h0001;
               ma_addr = opw;
               case (ir_r[11:10])
                  core_pkg::LW_JMP: begin
                     pc_nxt = opw;
                     ir_vld_nxt = 1'b0;
                  end
                  core_pkg::LW_CALL: begin
                     push = 1'b1;
                     push_pc = pc_r + 16'h0001;
                     sp_nxt = sp_r - core_pkg::RET_STEP;
                     pc_nxt = opw;
                     ir_vld_nxt = 1'b0;
                  end
                  core_pkg::LW_LDS: ma_en = 1'b1;
                  default: begin
                     ma_en = 1'b1;
                     ma_wr = 1'b1;
                  end
               endcase
            end
            core_pkg::OP_IO: begin
               ma_en = 1'b1;
               ma_wr = ir_r[11];
               // Six address bits cannot reach the extended window
               ma_addr = core_pkg::DS_IO_BASE + {10'h000, ir_r[10:5]};
            end
            core_pkg::OP_IND: begin
               ma_en = 1'b1;
               ma_wr = ir_r[9];
               ma_addr = {rf[p_wa + 5'h01], rf[p_wa]};
               p_we = ir_r[8];
            end
            default: ;
         endcase
      end
      if (ma_en && ma_wr) begin
         if (ma_addr < core_pkg::DS_IO_BASE) begin
            rf_we = 1'b1;
            rf_wa = ma_addr[4:0];
            rf_wd = ma_wd;
         end else if (ma_addr == core_pkg::DS_STATUS_FLAG_REGISTER) status_flag_register_nxt = ma_wd;
         else if (ma_addr == core_pkg::DS_SPL) sp_nxt[7:0] = ma_wd;
         else if (ma_addr == core_pkg::DS_SPH) sp_nxt[15:8] = ma_wd;
         else dm_we = (ma_addr < DS_SIZE);
      end else if (ma_en) begin
         rf_we = 1'b1;
         rf_wa = ma_rd;
         rf_wd = ds_read(ma_addr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK) begin
      if (!RST_B) state_r <= core_pkg::ST_HALT;
      else begin
         case (state_r)
            core_pkg::ST_HALT: if (ctrl_r[core_pkg::CTRL_RUN]) state_r <= core_pkg::ST_RUN;
            core_pkg::ST_RUN:  if (!ctrl_r[core_pkg::CTRL_RUN]) state_r <= core_pkg::ST_HALT;
            default:           state_r <= core_pkg::ST_HALT;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         pc_r <= core_pkg::PC_RST;
         ir_r <= 16'h0000;
         ir_pc_r <= 16'h0000;
         ir_vld_r <= 1'b0;
      end else if (halted && bus_wr && WB_REQ.adr == core_pkg::ADR_PC && &WB_REQ.sel[1:0]) begin
         pc_r <= WB_REQ.dat[15:0];
         ir_vld_r <= 1'b0;
      end else begin
         pc_r <= pc_nxt;
         ir_r <= ir_nxt;
         ir_pc_r <= ir_pc_nxt;
         ir_vld_r <= ir_vld_nxt;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) status_flag_register_r <= core_pkg::STATUS_FLAG_REGISTER_RST;
      else if (halted && bus_wr && WB_REQ.adr == core_pkg::ADR_STATUS && WB_REQ.sel[0])
         status_flag_register_r <= WB_REQ.dat[7:0];
      else status_flag_register_r <= status_flag_register_nxt;
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) sp_r <= SP_RST;
      else if (halted && bus_wr && WB_REQ.adr == core_pkg::ADR_SP && &WB_REQ.sel[1:0])
         sp_r <= WB_REQ.dat[15:0];
      else sp_r <= sp_nxt;
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         ctrl_r <= core_pkg::CTRL_RST;
         ien_r <= '0;
         boot_r <= core_pkg::BOOT_RST;
      end else if (bus_wr) begin
         if (WB_REQ.adr == core_pkg::ADR_CTRL && WB_REQ.sel[0]) ctrl_r <= WB_REQ.dat[7:0];
         if (WB_REQ.adr == core_pkg::ADR_IEN && WB_REQ.sel[0]) ien_r <= WB_REQ.dat[NIRQ-1:0];
         if (WB_REQ.adr == core_pkg::ADR_BOOT && &WB_REQ.sel[1:0]) boot_r <= WB_REQ.dat[15:0];
      end
   end

   // Register file: pointer update last so it wins over a clashing load
   always_ff @(posedge CLK) begin
      if (halted && bus_wr && WB_REQ.adr[7] && WB_REQ.sel[0])
         rf[WB_REQ.adr[6:2]] <= WB_REQ.dat[7:0];
      else begin
         if (rf_we) rf[rf_wa] <= rf_wd;
         if (p_we) begin
            rf[p_wa] <= p_wd[7:0];
            rf[p_wa + 5'h01] <= p_wd[15:8];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (dm_we) dmem[didx(ma_addr)] <= dm_wd;
      if (push) begin
         dmem[didx(sp_r)] <= push_pc[7:0];
         dmem[didx(sp_r - 16'h0001)] <= push_pc[15:8];
      end
   end

   always_ff @(posedge CLK) begin
      if (halted && bus_wr && WB_REQ.adr == core_pkg::ADR_PROG && &WB_REQ.sel)
         pmem[WB_REQ.dat[PAW+15:16]] <= WB_REQ.dat[15:0];
      else if (pm_we) pmem[zp[PAW-1:0]] <= pm_wd;
   end

   // Requests cross from another domain
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         irq_s1_r <= '0;
         irq_s2_r <= '0;
         irq_ack_r <= '0;
      end else begin
         irq_s1_r <= IRQ;
         irq_s2_r <= irq_s1_r;
         irq_ack_r <= ack_nxt;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) rsp_r <= '0;
      else begin
         rsp_r.ack <= acc & ~rsp_r.ack;
         rsp_r.dat <= 32'h0000_0000;
         if (WB_REQ.adr[7]) rsp_r.dat[7:0] <= rf[WB_REQ.adr[6:2]];
         else begin
            case (WB_REQ.adr)
               core_pkg::ADR_STATUS: rsp_r.dat[7:0] <= status_flag_register_r;
               core_pkg::ADR_CTRL:   rsp_r.dat[7:0] <= ctrl_r;
               core_pkg::ADR_PC:     rsp_r.dat[15:0] <= pc_r;
               core_pkg::ADR_SP:     rsp_r.dat[15:0] <= sp_r;
               core_pkg::ADR_IEN:    rsp_r.dat[NIRQ-1:0] <= ien_r;
               core_pkg::ADR_BOOT:   rsp_r.dat[15:0] <= boot_r;
               default:              rsp_r.dat <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign WB_RSP  = rsp_r;
   assign IRQ_ACK = irq_ack_r;
endmodule : exec_core

/* File: verification/exec_core_properties.sv */
/*
 Port checker for exec_core: bus handshake, readback and interrupt order.
 Assumes bind to exec_core and a master that holds each request to ack.
*/
`timescale 1ns/100ps
module exec_core_checker #(
   parameter int NIRQ = 8
) (
   input wire logic              CLK,
   input wire logic              RST_B,
   input wire core_pkg::wb_req_s WB_REQ,
   input wire core_pkg::wb_rsp_s WB_RSP,
   input wire logic [NIRQ-1:0]   IRQ,
   input wire logic [NIRQ-1:0]   IRQ_ACK
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   logic rd;
   assign rd = WB_RSP.ack && !WB_REQ.we;
   ////////////////////////////////////////////////////////////////////////////////
   ack_follows_req_a: assert property (WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack |=> WB_RSP.ack)
      else $error("bus request not acked next cycle");
   ack_single_pulse_a: assert property (WB_RSP.ack |=> !WB_RSP.ack)
      else $error("ack held too long");
   ack_needs_req_a: assert property ($rose(WB_RSP.ack) |-> $past(WB_REQ.cyc && WB_REQ.stb))
      else $error("ack without request");
   byte_read_narrow_a: assert property (rd && WB_REQ.adr == core_pkg::ADR_STATUS
      |-> WB_RSP.dat[31:8] == 24'h000000) else $error("status read too wide");
   sign_flag_xor_a: assert property (rd && WB_REQ.adr == core_pkg::ADR_STATUS
      |-> WB_RSP.dat[4] == (WB_RSP.dat[2] ^ WB_RSP.dat[3])) else $error("sign flag wrong");
   stack_read_narrow_a: assert property (rd && WB_REQ.adr == core_pkg::ADR_SP
      |-> WB_RSP.dat[31:16] == 16'h0000) else $error("stack top read too wide");
   // Take decision sees requests three edges before the acknowledge
   irq_lowest_wins_a: assert property (IRQ_ACK != '0 |-> $onehot(IRQ_ACK)
      && (IRQ_ACK & $past(IRQ, 3)) != '0 && ((IRQ_ACK - 1'b1) & $past(IRQ, 3)) == '0)
      else $error("interrupt taken out of priority");
   gate_closed_entry_a: assert property (IRQ_ACK != '0 |=> (IRQ_ACK == '0) [*2])
      else $error("second interrupt without gate reopen");
   cover property (WB_RSP.ack && WB_REQ.we);
   cover property (rd);
   cover property (IRQ_ACK != '0);
endmodule : exec_core_checker

bind exec_core exec_core_checker #(.NIRQ(NIRQ)) u_exec_core_checker (.CLK(CLK),
   .RST_B(RST_B), .WB_REQ(WB_REQ), .WB_RSP(WB_RSP), .IRQ(IRQ), .IRQ_ACK(IRQ_ACK));

/* File: verification/irq_src.sv */
/*
 Interrupt source model: level requests held until taken.
 Assumes the core's acknowledge pulse clears the matching request.
*/
`timescale 1ns/100ps
module irq_src #(
   parameter int N = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [N-1:0] raise,
   input  wire logic [N-1:0] ack,
   output logic      [N-1:0] irq
);
   // Level held, so a late take still sees its source
   always_ff @(posedge clk) begin
      if (!rst_b) irq <= '0;
      else irq <= (irq | raise) & ~ack;
   end
endmodule : irq_src

/* File: verification/tb.sv */
/*
 Self-checking bench for exec_core over the Wishbone register port.
 Assumes the package map; checks both the one-word and the two-word vector layout.
*/
`timescale 1ns/100ps
module tb;
   logic              CLK = 1'b0;
   logic              RST_B = 1'b0;
   core_pkg::wb_req_s req = '0;
   core_pkg::wb_rsp_s rsp;
   logic [7:0]        irq;
   logic [7:0]        irq_ack;
   logic [7:0]        raise = 8'h00;
   logic [31:0]       q;
   int                errors = 0;
   int                compares = 0;
   // Jump, vectors 2 and 5, then add 7F+01, open gate, spin on Z clear
   logic [31:0] prog [9] = '{32'h0000_4000, 32'h0001_0010, 32'h0003_0400,
      32'h0006_31FF, 32'h0010_807F, 32'h0011_8101, 32'h0012_C211, 32'h0013_0100,
      32'h0014_31FF};
   always #2 CLK = ~CLK;
   exec_core u_exec_core (.CLK(CLK), .RST_B(RST_B), .WB_REQ(req), .WB_RSP(rsp),
      .IRQ(irq), .IRQ_ACK(irq_ack));
   irq_src u_irq_src (.clk(CLK), .rst_b(RST_B), .raise(raise), .ack(irq_ack), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      if (errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      @(posedge CLK);
      req <= '{1'b1, 1'b1, we, 4'hF, a, d};
      do begin
         @(posedge CLK);
         n++;
      end while (rsp.ack !== 1'b1 && n < 100);
      r = rsp.dat;
      req <= '0;
      if (n >= 100) begin
         errors++;
         conclude();
      end
   endtask : wb
   task automatic wait_ack(input int b);
      int n;
      n = 0;
      while (irq_ack[b] !== 1'b1 && n < 400) begin
         @(posedge CLK);
         n++;
      end
      chk({31'h0, irq_ack[b]}, 32'h1);
      if (n >= 400) conclude();
      @(posedge CLK);
   endtask : wait_ack
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge CLK);
      RST_B <= 1'b1;
      wb(1'b0, core_pkg::ADR_STATUS, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b1, core_pkg::ADR_SP, 32'h01F0, q);
      foreach (prog[i]) wb(1'b1, core_pkg::ADR_PROG, prog[i], q);
      wb(1'b1, core_pkg::ADR_IEN, 32'hFF, q);
      // Both raised while the gate is still shut
      raise <= 8'h24;
      @(posedge CLK);
      raise <= 8'h00;
      wb(1'b1, core_pkg::ADR_CTRL, 32'h1, q);
      wait_ack(2);
      wait_ack(5);
      repeat (10) @(posedge CLK);
      wb(1'b1, core_pkg::ADR_CTRL, 32'h0, q);
      wb(1'b0, core_pkg::ADR_STATUS, 32'h0, q);
      chk(q, 32'h2C);
      wb(1'b0, 8'hC0, 32'h0, q); // Register 16 window
      chk(q, 32'h80);
      wb(1'b0, core_pkg::ADR_SP, 32'h0, q);
      chk(q, 32'h01EE);
      // Two-word vectors: source 2 lands on the spin at word 6, gate stays shut
      wb(1'b1, core_pkg::ADR_STATUS, 32'h80, q);
      wb(1'b1, core_pkg::ADR_PC, 32'h14, q);
      raise <= 8'h04;
      @(posedge CLK);
      raise <= 8'h00;
      wb(1'b1, core_pkg::ADR_CTRL, 32'h3, q);
      wait_ack(2);
      repeat (10) @(posedge CLK);
      wb(1'b1, core_pkg::ADR_CTRL, 32'h0, q);
      wb(1'b0, core_pkg::ADR_STATUS, 32'h0, q);
      chk(q, 32'h00);
      wb(1'b0, core_pkg::ADR_SP, 32'h0, q);
      chk(q, 32'h01EC);
      conclude();
   end
endmodule : tb
